// File: pin_timer_pkg.sv
// constants, field layouts and reset values shared by the enable pin control block
// assumes a 50 MHz mclk and a synchronous active-high reset
//
// Summary of operation
// - pin selectable: enable, powerdown, saving, profile, reset
// - pin function resets to plain output enable
// - saving mode with pin low (end device asleep) swaps first output to 32kHz
// - timeout choices 0.5, 1, 2, 4 seconds
// - expiry sets flag; clearing timer enable clears it
// - expiry drives one 250ms reset pulse if enabled
// - expiry returns to profile zero, then disables control
// - timer runs alongside dynamic frequency control
// - enable function gates only first single-ended output
// - powerdown low stops all but 32.768kHz output
// - powerdown, bus enable, own enable all gate outputs
// - profile function makes pin profile bit zero
package pin_timer_pkg;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 20; // mclk period
  localparam int TICK_PERIOD_NS = 1000000; // slow reference tick, 1 ms
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS; // mclk cycles per tick
  localparam int TICK_MS = 1; // tick period in ms
  localparam int TIMEOUT0_MS = 500;
  localparam int TIMEOUT1_MS = 1000;
  localparam int TIMEOUT2_MS = 2000;
  localparam int TIMEOUT3_MS = 4000;
  localparam int RESET_PULSE_MS = 250;
  localparam logic [11:0] TIMEOUT0_TICKS = 12'(TIMEOUT0_MS / TICK_MS);
  localparam logic [11:0] TIMEOUT1_TICKS = 12'(TIMEOUT1_MS / TICK_MS);
  localparam logic [11:0] TIMEOUT2_TICKS = 12'(TIMEOUT2_MS / TICK_MS);
  localparam logic [11:0] TIMEOUT3_TICKS = 12'(TIMEOUT3_MS / TICK_MS);
  localparam logic [11:0] RESET_PULSE_TICKS = 12'(RESET_PULSE_MS / TICK_MS);

  // ***************************************************************
  // register offsets (byte addresses)
  // ***************************************************************
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h008;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h00C;

  // ***************************************************************
  // control field positions
  // ***************************************************************
  localparam int CTRL_FUNC_LSB = 0; // [1:0] pin function
  localparam int CTRL_BUS_OE = 2;
  localparam int CTRL_TMR_EN = 3;
  localparam int CTRL_TSEL_LSB = 4; // [5:4] timeout select
  localparam int CTRL_RST_EN = 6;
  localparam int CTRL_DFC_EN = 7;
  localparam int CTRL_OUT_EN_LSB = 8; // [12:8] per-output enables
  localparam int CTRL_LOW32K_EN = 13;
  localparam int CTRL_PROF_LSB = 14; // [15:14] software profile

  // status field positions
  localparam int STAT_FLAG = 0;
  localparam int STAT_PIN = 1;
  localparam int STAT_ASLEEP = 2;
  localparam int STAT_PROF_LSB = 3; // [4:3]
  localparam int STAT_PULSE = 5;
  localparam int STAT_PD = 6;

  // interrupt bits
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_PIN_EDGE = 1;
  localparam int IRQ_W = 2;

  // ***************************************************************
  // pin function codes and reset values
  // ***************************************************************
  localparam logic [1:0] FUNC_OE = 2'h0;
  localparam logic [1:0] FUNC_PD = 2'h1;
  localparam logic [1:0] FUNC_PPS = 2'h2;
  localparam logic [1:0] FUNC_DFC = 2'h3;
  localparam int N_OUT = 5; // single_ended_out_a, b, c, diff_out_a, diff_out_b
  localparam logic [1:0] FUNC_RST = FUNC_OE;
  localparam logic BUS_OE_RST = 1'b1;
  localparam logic [4:0] OUT_EN_RST = 5'h1F;
  localparam logic [1:0] TSEL_RST = 2'h0;
  localparam logic [1:0] PROF_RST = 2'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

  typedef enum logic [1:0] {
    TMR_IDLE,
    TMR_COUNT,
    TMR_DONE
  } tmr_state_e;

endpackage

// File: timer_if.sv
// handshake and status signals between the pin control block and its timer
// assumes both ends run on the same mclk
`timescale 1ns/1ps
`default_nettype none
interface timer_if;
  logic enable; // timer enable bit
  logic [1:0] sel; // timeout select
  logic reset_en; // reset pulse allowed
  logic expired; // one-cycle pulse at timeout
  logic flag; // sticky timeout flag
  logic pulse; // reset pulse active
  logic pulse_done; // one-cycle pulse at pulse end

  modport ctrl (output enable, output sel, output reset_en,
                input expired, input flag, input pulse, input pulse_done);
  modport tmr (input enable, input sel, input reset_en,
               output expired, output flag, output pulse, output pulse_done);
endinterface
`default_nettype wire

// File: timeout_timer.sv
// timeout timer counting a slow tick made from mclk, with reset pulse
// assumes enable and select come from registers on the same clock
`timescale 1ns/1ps
`default_nettype none
module timeout_timer #(
  parameter int TICK_CYCLES = pin_timer_pkg::TICK_CYCLES_DEF
) (
  input wire logic mclk,
  input wire logic rst,
  timer_if.tmr tif
);
  import pin_timer_pkg::*;

  // all timer state
  typedef struct packed {
    tmr_state_e st; // idle, counting or expired
    logic [15:0] presc; // mclk cycles within a tick
    logic [11:0] cnt; // ticks since enable
    logic [11:0] pcnt; // ticks within reset pulse
    logic en_prev; // enable one cycle ago
    logic flag; // sticky timeout flag
    logic pulse; // reset pulse on
    logic expired; // expiry strobe
    logic pdone; // pulse end strobe
  } tmr_s;

  tmr_s s_q, s_d;
  logic tick; // free-running tick, independent of enable
  logic [11:0] limit; // selected timeout in ticks

  // tick from the free-running prescaler
  assign tick = (s_q.presc == 16'(TICK_CYCLES - 1));

  // timeout select decode
  always_comb begin
    case (tif.sel)
      2'h0: limit = TIMEOUT0_TICKS;
      2'h1: limit = TIMEOUT1_TICKS;
      2'h2: limit = TIMEOUT2_TICKS;
      default: limit = TIMEOUT3_TICKS;
    endcase
  end

  // next state
  always_comb begin
    s_d = s_q;
    s_d.expired = 1'b0;
    s_d.pdone = 1'b0;
    s_d.en_prev = tif.enable;
    s_d.presc = tick ? 16'h0000 : s_q.presc + 16'h0001;
    case (s_q.st)
      TMR_IDLE: begin
        // rising enable restarts from zero
        if (tif.enable && !s_q.en_prev) begin
          s_d.st = TMR_COUNT;
          s_d.cnt = 12'h000;
        end
      end
      TMR_COUNT: begin
        if (!tif.enable) begin
          s_d.st = TMR_IDLE;
        end else if (tick) begin
          if (s_q.cnt == limit - 12'h001) begin
            s_d.st = TMR_DONE;
            s_d.expired = 1'b1;
            s_d.flag = 1'b1;
            s_d.pulse = tif.reset_en;
            s_d.pcnt = 12'h000;
          end else begin
            s_d.cnt = s_q.cnt + 12'h001;
          end
        end
      end
      default: begin
        // one shot: wait for software to drop enable
        if (!tif.enable) begin
          s_d.st = TMR_IDLE;
        end
      end
    endcase
    // flag clears when enable is written to zero; a zero enable in the expiry cycle blocks the expiry, so the clear wins
    if (!tif.enable && !s_d.expired) begin
      s_d.flag = 1'b0;
    end
    // reset pulse runs its full length once started
    if (s_q.pulse && tick) begin
      if (s_q.pcnt == RESET_PULSE_TICKS - 12'h001) begin
        s_d.pulse = 1'b0;
        s_d.pdone = 1'b1;
      end else begin
        s_d.pcnt = s_q.pcnt + 12'h001;
      end
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tif.expired = s_q.expired;
  assign tif.flag = s_q.flag;
  assign tif.pulse = s_q.pulse;
  assign tif.pulse_done = s_q.pdone;

  // ***************************************************************
  // checks
  // ***************************************************************
  a_flag_on_expiry: assert property (@(posedge mclk) disable iff (rst)
    s_q.expired |-> s_q.flag) else $error("flag not set at expiry");
  a_flag_clear: assert property (@(posedge mclk) disable iff (rst)
    (!tif.enable && !s_d.expired) |=> !s_q.flag) else $error("flag not cleared");
  a_pulse_only_en: assert property (@(posedge mclk) disable iff (rst)
    $rose(s_q.pulse) |-> $past(tif.reset_en) && s_q.expired) else $error("stray pulse");
  a_no_count_idle: assert property (@(posedge mclk) disable iff (rst)
    (s_q.st == TMR_IDLE) |-> !s_q.expired) else $error("expiry while idle");
  a_restart_zero: assert property (@(posedge mclk) disable iff (rst)
    (s_q.st == TMR_IDLE && tif.enable && !s_q.en_prev) |=> s_q.cnt == 12'h000)
    else $error("count not restarted");
endmodule // timeout_timer
`default_nettype wire

// File: enable_pin_and_timeout_timer.sv
// enable pin control: pin function, output gating, profile select, timer, apb registers
// assumes an apb master on mclk and an asynchronous pin from the board
`timescale 1ns/1ps
`default_nettype none
module enable_pin_and_timeout_timer #(
  parameter int TICK_CYCLES = pin_timer_pkg::TICK_CYCLES_DEF
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic multi_function_pin_in,
  output logic multi_function_pin_out,
  output logic multi_function_pin_oe,
  output logic [pin_timer_pkg::N_OUT-1:0] out_run,
  output logic se_a_low_clk_sel,
  output logic low32k_run,
  output logic core_powerdown,
  output logic [1:0] freq_profile,
  output logic irq
);
  import pin_timer_pkg::*;

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic [1:0] func; // pin function select
    logic bus_oe; // bus output-enable bit
    logic tmr_en; // timer enable
    logic [1:0] tsel; // timeout select
    logic rst_en; // reset output control
    logic dfc_en; // dynamic frequency control enable
    logic [N_OUT-1:0] out_en; // per-output enables
    logic low32k_en; // low-frequency output enable
    logic [1:0] prof_sw; // software profile
    logic [IRQ_W-1:0] irq_stat; // sticky events
    logic [IRQ_W-1:0] irq_mask; // event masks
    logic [31:0] rdata; // read data, loaded in setup
    logic s1; // pin synchroniser stages
    logic s2;
    logic s3;
    logic pin_lvl; // filtered pin level
  } top_s;

  top_s s_q, s_d;
  timer_if tif();
  logic wr_acc; // write access phase
  logic setup; // setup phase
  logic hit_ctrl, hit_stat, hit_istat, hit_imask, hit_any;
  logic pd_n; // effective powerdown input, high = powered
  logic asleep; // end device asleep in saving mode
  logic pin_edge; // filtered pin changed
  logic [31:0] ctrl_word, stat_word;
  logic [IRQ_W-1:0] ev;

  // ***************************************************************
  // timer
  // ***************************************************************
  // the timer only reads its own bits, so it works with or without dfc
  assign tif.enable = s_q.tmr_en;
  assign tif.sel = s_q.tsel;
  assign tif.reset_en = s_q.rst_en;

  timeout_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .mclk(mclk),
    .rst(rst),
    .tif(tif)
  );

  // ***************************************************************
  // apb decode
  // ***************************************************************
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;

  // address decode
  always_comb begin
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    hit_istat = 1'b0;
    hit_imask = 1'b0;
    if (paddr == CTRL_OFS) begin
      hit_ctrl = 1'b1;
    end else if (paddr == STATUS_OFS) begin
      hit_stat = 1'b1;
    end else if (paddr == IRQ_STAT_OFS) begin
      hit_istat = 1'b1;
    end else if (paddr == IRQ_MASK_OFS) begin
      hit_imask = 1'b1;
    end
  end
  assign hit_any = hit_ctrl || hit_stat || hit_istat || hit_imask;

  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;
  assign prdata = s_q.rdata;

  // ***************************************************************
  // pin function and gating
  // ***************************************************************
  // powerdown input only acts when the pin is given that job
  assign pd_n = (s_q.func == FUNC_PD) ? s_q.pin_lvl : 1'b1;
  // low pin in saving mode means the end device went to sleep
  assign asleep = (s_q.func == FUNC_PPS) && !s_q.pin_lvl;
  assign pin_edge = (s_q.s2 == s_q.s3) && (s_q.s3 != s_q.pin_lvl);

  // output gating
  always_comb begin
    for (int i = 0; i < N_OUT; i++) begin
      // powerdown low wins over everything, then bus and own enables
      out_run[i] = pd_n && s_q.bus_oe && s_q.out_en[i];
    end
    if (s_q.func == FUNC_OE) begin
      out_run[0] = out_run[0] && s_q.pin_lvl;
    end
  end
  // the first output keeps running on the slow clock while the end device sleeps
  assign se_a_low_clk_sel = asleep;
  // the low-frequency clock output survives powerdown, gated only by its own enable
  assign low32k_run = s_q.low32k_en;
  assign core_powerdown = !pd_n;

  // profile select: zero while disabled or after a timeout
  always_comb begin
    if (!s_q.dfc_en || tif.flag) begin
      freq_profile = 2'h0;
    end else if (s_q.func == FUNC_DFC) begin
      freq_profile = {1'b0, s_q.pin_lvl};
    end else begin
      freq_profile = s_q.prof_sw;
    end
  end

  // pin becomes a reset output, held high and pulled low for the pulse
  // a pulse already started keeps the drive even if software drops the bit
  assign multi_function_pin_oe = s_q.rst_en || tif.pulse;
  assign multi_function_pin_out = !tif.pulse;

  // ***************************************************************
  // register images
  // ***************************************************************
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[CTRL_FUNC_LSB +: 2] = s_q.func;
    ctrl_word[CTRL_BUS_OE] = s_q.bus_oe;
    ctrl_word[CTRL_TMR_EN] = s_q.tmr_en;
    ctrl_word[CTRL_TSEL_LSB +: 2] = s_q.tsel;
    ctrl_word[CTRL_RST_EN] = s_q.rst_en;
    ctrl_word[CTRL_DFC_EN] = s_q.dfc_en;
    ctrl_word[CTRL_OUT_EN_LSB +: N_OUT] = s_q.out_en;
    ctrl_word[CTRL_LOW32K_EN] = s_q.low32k_en;
    ctrl_word[CTRL_PROF_LSB +: 2] = s_q.prof_sw;
    stat_word = 32'h0000_0000;
    stat_word[STAT_FLAG] = tif.flag;
    stat_word[STAT_PIN] = s_q.pin_lvl;
    stat_word[STAT_ASLEEP] = asleep;
    stat_word[STAT_PROF_LSB +: 2] = freq_profile;
    stat_word[STAT_PULSE] = tif.pulse;
    stat_word[STAT_PD] = !pd_n;
  end

  // interrupt events
  assign ev[IRQ_TIMEOUT] = tif.expired;
  assign ev[IRQ_PIN_EDGE] = pin_edge;
  assign irq = |(s_q.irq_stat & s_q.irq_mask);

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    s_d = s_q;
    // three-stage synchroniser; the first stage feeds only the second
    s_d.s1 = multi_function_pin_in;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    if (s_q.s2 == s_q.s3) begin
      s_d.pin_lvl = s_q.s3;
    end
    // read data captured in setup, stable through the access phase
    if (setup) begin
      if (hit_ctrl) begin
        s_d.rdata = ctrl_word;
      end else if (hit_stat) begin
        s_d.rdata = stat_word;
      end else if (hit_istat) begin
        s_d.rdata = {30'h0, s_q.irq_stat};
      end else if (hit_imask) begin
        s_d.rdata = {30'h0, s_q.irq_mask};
      end else begin
        s_d.rdata = 32'h0000_0000;
      end
    end
    // register writes
    if (wr_acc && hit_ctrl) begin
      s_d.func = pwdata[CTRL_FUNC_LSB +: 2];
      s_d.bus_oe = pwdata[CTRL_BUS_OE];
      s_d.tmr_en = pwdata[CTRL_TMR_EN];
      s_d.tsel = pwdata[CTRL_TSEL_LSB +: 2];
      s_d.rst_en = pwdata[CTRL_RST_EN];
      s_d.dfc_en = pwdata[CTRL_DFC_EN];
      s_d.out_en = pwdata[CTRL_OUT_EN_LSB +: N_OUT];
      s_d.low32k_en = pwdata[CTRL_LOW32K_EN];
      s_d.prof_sw = pwdata[CTRL_PROF_LSB +: 2];
    end
    if (wr_acc && hit_imask) begin
      s_d.irq_mask = pwdata[IRQ_W-1:0];
    end
    // write one to clear, with a new event winning over the clear
    if (wr_acc && hit_istat) begin
      s_d.irq_stat = s_q.irq_stat & ~pwdata[IRQ_W-1:0];
    end
    s_d.irq_stat = s_d.irq_stat | ev;
    // dfc is switched off once the reset event is over; hardware wins over a write
    if (s_q.dfc_en && ((tif.expired && !tif.pulse) || tif.pulse_done)) begin
      s_d.dfc_en = 1'b0;
    end
  end

  // state register; function comes up as plain output enable
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
      s_q.func <= FUNC_RST;
      s_q.bus_oe <= BUS_OE_RST;
      s_q.tsel <= TSEL_RST;
      s_q.out_en <= OUT_EN_RST;
      s_q.prof_sw <= PROF_RST;
      s_q.irq_mask <= IRQ_MASK_RST;
      s_q.s1 <= 1'b1;
      s_q.s2 <= 1'b1;
      s_q.s3 <= 1'b1;
      s_q.pin_lvl <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  // output gating
  a_pd_stops_all: assert property (@(posedge mclk) disable iff (rst)
    (s_q.func == FUNC_PD && !s_q.pin_lvl) |-> (out_run == '0)) else $error("outputs run in powerdown");

  a_slow_clk_kept: assert property (@(posedge mclk) disable iff (rst)
    (core_powerdown && s_q.low32k_en) |-> low32k_run) else $error("slow output stopped in powerdown");

  a_gate_priority: assert property (@(posedge mclk) disable iff (rst)
    !s_q.bus_oe |-> (out_run == '0)) else $error("output runs without bus enable");

  a_gate_running: assert property (@(posedge mclk) disable iff (rst)
    (pd_n && s_q.bus_oe && s_q.func != FUNC_OE) |-> (out_run == s_q.out_en))
    else $error("enabled output stopped");

  a_oe_first_only: assert property (@(posedge mclk) disable iff (rst)
    (s_q.func == FUNC_OE && pd_n && s_q.bus_oe) |-> (out_run[N_OUT-1:1] == s_q.out_en[N_OUT-1:1]))
    else $error("pin gates other outputs");

  // pin function and filter
  a_func_default: assert property (@(posedge mclk)
    $fell(rst) |-> (s_q.func == FUNC_RST)) else $error("pin function not plain enable after reset");

  a_pin_filtered: assert property (@(posedge mclk) disable iff (rst)
    $changed(s_q.pin_lvl) |-> ($past(s_q.s2) == $past(s_q.s3))) else $error("pin level taken early");

  a_pps_switch: assert property (@(posedge mclk) disable iff (rst)
    (s_q.func == FUNC_PPS && $fell(s_q.pin_lvl)) |-> se_a_low_clk_sel) else $error("no slow clock swap");

  a_ctrl_write: assert property (@(posedge mclk) disable iff (rst)
    (wr_acc && hit_ctrl) |=> (s_q.func == $past(pwdata[CTRL_FUNC_LSB +: 2])))
    else $error("function write lost");

  // profile, reset output and events
  a_profile_zero: assert property (@(posedge mclk) disable iff (rst)
    tif.flag |-> (freq_profile == 2'h0)) else $error("profile not zero after timeout");

  a_dfc_off_end: assert property (@(posedge mclk) disable iff (rst)
    (s_q.dfc_en && tif.pulse_done) |=> !s_q.dfc_en) else $error("profile control on after pulse");

  a_dfc_off_nopulse: assert property (@(posedge mclk) disable iff (rst)
    (s_q.dfc_en && tif.expired && !tif.pulse) |=> !s_q.dfc_en) else $error("profile control on after expiry");

  a_dfc_pin_bit0: assert property (@(posedge mclk) disable iff (rst)
    (s_q.dfc_en && !tif.flag && s_q.func == FUNC_DFC) |-> (freq_profile == {1'b0, s_q.pin_lvl}))
    else $error("pin not profile bit zero");

  a_reset_pin_drv: assert property (@(posedge mclk) disable iff (rst)
    tif.pulse |-> (multi_function_pin_oe && !multi_function_pin_out)) else $error("reset pulse not driven");

  a_irq_sticky: assert property (@(posedge mclk) disable iff (rst)
    tif.expired |=> s_q.irq_stat[IRQ_TIMEOUT]) else $error("timeout event lost");

  a_stat_w1c: assert property (@(posedge mclk) disable iff (rst)
    (wr_acc && hit_istat && pwdata[IRQ_TIMEOUT] && !tif.expired) |=> !s_q.irq_stat[IRQ_TIMEOUT])
    else $error("timeout event not cleared");
endmodule // enable_pin_and_timeout_timer
`default_nettype wire

// File: pin_board_model.sv
// board side of the multi-function pin: the end device drives a level
// assumes one mclk domain; the bench commands the level it wants
`timescale 1ns/1ps
`default_nettype none
module pin_board_model (
  input wire logic mclk,
  input wire logic board_level, // level the end device wants to show
  input wire logic dev_out, // block's pin drive value
  input wire logic dev_oe, // block drives the pin
  output logic pin_in // resolved wire level seen by the block
);
  // ***************************************************************
  // pin resolution
  // ***************************************************************
  logic drv_q; // board drive, changes just after an edge
  // in saving mode, low means the end device has gone to sleep
  always_ff @(posedge mclk) begin
    drv_q <= board_level;
  end
  // the block wins whenever it drives the pin as a reset output, the board yields
  assign pin_in = dev_oe ? dev_out : drv_q;
endmodule // pin_board_model
`default_nettype wire

// File: tb.sv
// self-checking bench for the enable pin and timeout timer block
// assumes the design files and pin_board_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pin_timer_pkg::*;
  // ***************************************************************
  // signals
  // ***************************************************************
  localparam int TK = 4; // short tick keeps timeouts in thousands of cycles
  logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, level = 1;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, pin_in, pin_out, pin_oe, lowsel, l32, pd, irq;
  logic [N_OUT-1:0] out_run;
  logic [1:0] prof;
  int mismatches = 0, samples_checked = 0, n;
  // free-running 50 MHz clock
  initial begin
    forever #10 mclk = ~mclk;
  end
  enable_pin_and_timeout_timer #(.TICK_CYCLES(TK)) i_enable_pin_and_timeout_timer (.mclk(mclk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .multi_function_pin_in(pin_in), .multi_function_pin_out(pin_out),
    .multi_function_pin_oe(pin_oe), .out_run(out_run), .se_a_low_clk_sel(lowsel), .low32k_run(l32),
    .core_powerdown(pd), .freq_profile(prof), .irq(irq));
  pin_board_model i_pin_board_model (.mclk(mclk), .board_level(level), .dev_out(pin_out), .dev_oe(pin_oe),
    .pin_in(pin_in));
  // ***************************************************************
  // shared tasks
  // ***************************************************************
  task automatic end_sim();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1; // let the write's register updates land before any look
  endtask
  task automatic wctrl(input logic [31:0] d);
    apb(1'b1, CTRL_OFS, d);
  endtask
  // the pin passes a synchroniser, so give it a few cycles to show
  task automatic pin(input logic v);
    @(posedge mclk);
    level <= v;
    repeat (8) @(posedge mclk);
    #1;
  endtask
  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_reset();
    apb(1'b0, CTRL_OFS, '0);
    chk(rd, 32'h0000_1F04, "ctrl reset");
    apb(1'b0, STATUS_OFS, '0);
    chk(rd, 32'h0000_0002, "status reset");
    chk({pin_oe, pin_out, irq, prof, out_run}, {22'h0, 5'h08, 5'h1F}, "outputs reset");
  endtask
  task automatic t_gate();
    wctrl(32'h0000_1F04);
    pin(1'b0);
    chk(out_run, 32'h1E, "enable gates only output a");
    wctrl(32'h0000_1F00);
    chk(out_run, 32'h00, "bus enable off stops all");
    pin(1'b1);
    wctrl(32'h0000_0504);
    chk(out_run, 32'h05, "own enables");
  endtask
  task automatic t_pd();
    wctrl(32'h0000_3F05);
    pin(1'b0);
    chk({pd, l32, out_run}, 32'h60, "powerdown low");
    pin(1'b1);
    chk({pd, l32, out_run}, 32'h3F, "powerdown high");
  endtask
  task automatic t_pps();
    wctrl(32'h0000_1F06);
    pin(1'b0);
    chk(lowsel, 32'h1, "asleep selects slow clock");
    apb(1'b0, STATUS_OFS, '0);
    chk(rd[STAT_ASLEEP], 32'h1, "asleep status");
    pin(1'b1);
    chk(lowsel, 32'h0, "awake selects normal clock");
  endtask
  task automatic t_dfc();
    wctrl(32'h0000_1F87);
    pin(1'b1);
    chk(prof, 32'h1, "pin high profile");
    pin(1'b0);
    chk(prof, 32'h0, "pin low profile");
    wctrl(32'h0000_DF84);
    chk(prof, 32'h3, "software profile");
    wctrl(32'h0000_DF04);
    chk(prof, 32'h0, "control off gives profile zero");
    pin(1'b1);
  endtask
  task automatic t_irq();
    apb(1'b1, IRQ_STAT_OFS, 32'h3);
    apb(1'b1, IRQ_MASK_OFS, 32'h0);
    pin(1'b0);
    chk(irq, 32'h0, "masked event");
    apb(1'b0, IRQ_STAT_OFS, '0);
    chk(rd, 32'h2, "pin change sticky");
    apb(1'b1, IRQ_MASK_OFS, 32'h2);
    chk(irq, 32'h1, "unmasked event");
    apb(1'b1, IRQ_STAT_OFS, 32'h2);
    chk(irq, 32'h0, "event cleared");
    pin(1'b1);
    apb(1'b0, 12'h010, '0);
    chk({31'h0, err}, 32'h1, "unmapped address error");
    chk(rd, 32'h0, "unmapped read data");
    apb(1'b1, STATUS_OFS, 32'hFFFF_FFFF);
    apb(1'b0, STATUS_OFS, '0);
    chk(rd, 32'h2, "status is read only");
  endtask
  // timer off clears the flag, then on restarts the count from zero
  task automatic t_timer(input logic [1:0] s, input logic [31:0] x, input int lim);
    apb(1'b1, IRQ_MASK_OFS, 32'h1);
    wctrl(x);
    apb(1'b1, IRQ_STAT_OFS, 32'h3);
    wctrl(x | 32'h8 | (32'(s) << 4));
    n = 0;
    while (irq !== 1'b1 && n < 20000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(32'(n >= lim * TK - 8 && n <= lim * TK + 8), 32'h1, "expiry time");
    apb(1'b0, STATUS_OFS, '0);
    chk(rd[STAT_FLAG], 32'h1, "flag set");
    chk(prof, 32'h0, "profile zero after expiry");
    chk({pin_oe, pin_out}, {30'h0, x[6], ~x[6]}, "reset output");
    wctrl(x);
    apb(1'b0, STATUS_OFS, '0);
    chk(rd[STAT_FLAG], 32'h0, "flag cleared");
  endtask
  // reset out and profile control on, profile 2 from software
  task automatic t_reset_out();
    t_timer(2'd0, 32'h0000_9FC4, 500);
    n = 0;
    while (pin_out !== 1'b1 && n < 2000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(32'(n >= 975 && n <= 1000), 32'h1, "pulse length");
    apb(1'b0, CTRL_OFS, '0);
    chk(rd[CTRL_DFC_EN], 32'h0, "control disabled after reset");
  endtask
  // ***************************************************************
  // main sequence and watchdog
  // ***************************************************************
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_gate();
    t_pd();
    t_pps();
    t_dfc();
    t_irq();
    t_reset_out();
    t_timer(2'd1, 32'h0000_9F84, 1000);
    t_timer(2'd2, 32'h0000_1F04, 2000);
    t_timer(2'd3, 32'h0000_1F04, 4000);
    end_sim();
  end
  // the whole run needs about 31000 cycles
  initial begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    end_sim();
  end
endmodule // tb
`default_nettype wire
